// File: core/fault_pkg.sv
// Constants, types and register map of the servo alarm and fault reporter
// Behaviour
// - Any alarm enters fault, servo output off
// - Fault state shows as status bit 3
// - Alarm output pin asserted on alarm
// - Alarm code readable as decimal value
// - LED flashes red/green pattern on alarm
// - Green flash count equals ones digit
// - Separate flash group carries tens digit
// - Codes: overcurrent 11, overload 21, overspeed 31
package fault_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned FLASH_ON_MS = 250;
  localparam int unsigned FLASH_OFF_MS = 250;
  localparam int unsigned GROUP_GAP_MS = 1000;
  localparam int unsigned REPEAT_GAP_MS = 2000;
  localparam int unsigned FLASH_ON_CYC = FLASH_ON_MS * CYC_PER_MS;
  localparam int unsigned FLASH_OFF_CYC = FLASH_OFF_MS * CYC_PER_MS;
  localparam int unsigned GROUP_GAP_CYC = GROUP_GAP_MS * CYC_PER_MS;
  localparam int unsigned REPEAT_GAP_CYC = REPEAT_GAP_MS * CYC_PER_MS;
  localparam logic [7:0] ADDR_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_CODE = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
  localparam int FLAG_SERVO_ON = 0;
  localparam int FLAG_FAULT = 3;
  localparam int CTRL_SERVO_REQ = 0;
  localparam int CTRL_ALARM_RESET = 1;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_CLEARED = 1;
  localparam int NUM_IRQ = 2;
  localparam int NUM_ALARM = 3;
  localparam logic [3:0] OC_TENS = 4'h1;
  localparam logic [3:0] OL_TENS = 4'h2;
  localparam logic [3:0] OS_TENS = 4'h3;
  localparam logic [3:0] ALL_ONES = 4'h1;
  localparam logic [7:0] CODE_TEN = 8'h0a;
  typedef struct packed {
    logic overspeed;
    logic overload;
    logic overcurrent;
  } alarm_in_t;
  typedef struct packed {
    logic red;
    logic green;
  } led_t;
  typedef enum logic [2:0] {
    FL_IDLE = 3'h0,
    FL_RED_ON = 3'h1,
    FL_RED_OFF = 3'h3,
    FL_GAP = 3'h2,
    FL_GRN_ON = 3'h6,
    FL_GRN_OFF = 3'h7,
    FL_PAUSE = 3'h5
  } flash_state_t;
endpackage : fault_pkg

// File: core/led_flasher.sv
// Two-colour LED flash code generator for a two-digit alarm code
`timescale 1ns/1ps
module led_flasher #(
  parameter int unsigned ON_CYC = fault_pkg::FLASH_ON_CYC,
  parameter int unsigned OFF_CYC = fault_pkg::FLASH_OFF_CYC,
  parameter int unsigned GAP_CYC = fault_pkg::GROUP_GAP_CYC,
  parameter int unsigned PAUSE_CYC = fault_pkg::REPEAT_GAP_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic [3:0] tens,
  input wire logic [3:0] ones,
  output fault_pkg::led_t led
);
  fault_pkg::flash_state_t state, next_state;
  logic [31:0] tmr, next_tmr;
  logic [3:0] cnt, next_cnt;
  wire done = (tmr == 32'h0);
  wire [31:0] on_ld = 32'(ON_CYC - 1);
  wire [31:0] off_ld = 32'(OFF_CYC - 1);
  wire [31:0] gap_ld = 32'(GAP_CYC - 1);
  wire [31:0] pause_ld = 32'(PAUSE_CYC - 1);
  wire [3:0] cnt_inc = cnt + 4'h1;

  always_comb begin
    next_state = state;
    next_tmr = done ? tmr : tmr - 32'h1;
    next_cnt = cnt;
    case (state)
      fault_pkg::FL_IDLE, fault_pkg::FL_PAUSE: begin
        if (state == fault_pkg::FL_IDLE || done) begin
          next_cnt = 4'h0;
          next_tmr = on_ld;
          // Tens group first, a zero tens digit skips its group; a zero ones digit is skipped only from the gap after red
          next_state = (tens != 4'h0) ? fault_pkg::FL_RED_ON : fault_pkg::FL_GRN_ON;
        end
      end
      fault_pkg::FL_RED_ON: begin
        if (done) begin
          next_state = fault_pkg::FL_RED_OFF;
          next_tmr = off_ld;
          next_cnt = cnt_inc;
        end
      end
      fault_pkg::FL_RED_OFF: begin
        if (done && cnt == tens) begin
          next_state = fault_pkg::FL_GAP;
          next_tmr = gap_ld;
          next_cnt = 4'h0;
        end else if (done) begin
          next_state = fault_pkg::FL_RED_ON;
          next_tmr = on_ld;
        end
      end
      fault_pkg::FL_GAP: begin
        if (done) begin
          next_state = (ones != 4'h0) ? fault_pkg::FL_GRN_ON : fault_pkg::FL_PAUSE;
          next_tmr = (ones != 4'h0) ? on_ld : pause_ld;
        end
      end
      fault_pkg::FL_GRN_ON: begin
        if (done) begin
          next_state = fault_pkg::FL_GRN_OFF;
          next_tmr = off_ld;
          next_cnt = cnt_inc;
        end
      end
      fault_pkg::FL_GRN_OFF: begin
        if (done && cnt == ones) begin
          next_state = fault_pkg::FL_PAUSE;
          next_tmr = pause_ld;
        end else if (done) begin
          next_state = fault_pkg::FL_GRN_ON;
          next_tmr = on_ld;
        end
      end
      default: next_state = fault_pkg::FL_IDLE;
    endcase
    if (!run) begin
      next_state = fault_pkg::FL_IDLE;
      next_tmr = 32'h0;
      next_cnt = 4'h0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= fault_pkg::FL_IDLE;
      tmr <= 32'h0;
      cnt <= 4'h0;
      led <= '0;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
      cnt <= next_cnt;
      led.red <= (next_state == fault_pkg::FL_RED_ON);
      led.green <= (next_state == fault_pkg::FL_GRN_ON);
    end
  end

  // Helper: green and red rising edges seen in the current cycle of the pattern
  logic [3:0] g_seen, r_seen;
  logic g_d, r_d;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      g_seen <= 4'h0;
      r_seen <= 4'h0;
      g_d <= 1'b0;
      r_d <= 1'b0;
    end else begin
      g_d <= led.green;
      r_d <= led.red;
      g_seen <= (state == fault_pkg::FL_IDLE || state == fault_pkg::FL_PAUSE) ? 4'h0 :
                g_seen + {3'h0, led.green & ~g_d};
      r_seen <= (state == fault_pkg::FL_IDLE || state == fault_pkg::FL_PAUSE) ? 4'h0 :
                r_seen + {3'h0, led.red & ~r_d};
    end
  end

  a_green_count: assert property (@(posedge clk) disable iff (!nrst)
    (state == fault_pkg::FL_GRN_OFF && next_state == fault_pkg::FL_PAUSE && run)
      |-> (g_seen == ones))
    else $error("green flash count differs from ones digit");
  a_red_count: assert property (@(posedge clk) disable iff (!nrst)
    (state == fault_pkg::FL_RED_OFF && next_state == fault_pkg::FL_GAP && run)
      |-> (r_seen == tens))
    else $error("red flash count differs from tens digit");
endmodule : led_flasher

// File: core/servo_alarm_fault_reporter.sv
// Alarm latch, fault state, alarm pin, APB registers and LED code of a servo driver
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
module servo_alarm_fault_reporter #(
  parameter int unsigned ON_CYC = fault_pkg::FLASH_ON_CYC,
  parameter int unsigned OFF_CYC = fault_pkg::FLASH_OFF_CYC,
  parameter int unsigned GAP_CYC = fault_pkg::GROUP_GAP_CYC,
  parameter int unsigned PAUSE_CYC = fault_pkg::REPEAT_GAP_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input fault_pkg::alarm_in_t alarm_in,
  output logic servo_out_en,
  output logic fault_output_pin,
  output fault_pkg::led_t led,
  output logic irq
);

  // Detector levels come from outside this clock domain
  logic [fault_pkg::NUM_ALARM-1:0] sync1, alarm_sync;
  wire [fault_pkg::NUM_ALARM-1:0] alarm_raw = alarm_in;

  genvar gi;
  generate
    for (gi = 0; gi < fault_pkg::NUM_ALARM; gi++) begin : g_sync
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          sync1[gi] <= 1'b0;
          alarm_sync[gi] <= 1'b0;
        end else begin
          sync1[gi] <= alarm_raw[gi];
          alarm_sync[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  fault_pkg::alarm_in_t alarm_now;
  assign alarm_now = alarm_sync;
  wire any_alarm = |alarm_sync;

  // APB decode
  wire apb_access = psel & penable;
  wire apb_done = apb_access & pready;
  wire next_pready = apb_access & ~pready;
  wire wr_en = apb_done & pwrite;
  wire sel_flags = (paddr == fault_pkg::ADDR_FLAGS);
  wire sel_code = (paddr == fault_pkg::ADDR_CODE);
  wire sel_ctrl = (paddr == fault_pkg::ADDR_CTRL);
  wire sel_stat = (paddr == fault_pkg::ADDR_IRQ_STAT);
  wire sel_clr = (paddr == fault_pkg::ADDR_IRQ_CLR);
  wire sel_en = (paddr == fault_pkg::ADDR_IRQ_EN);
  wire mapped = sel_flags | sel_code | sel_ctrl | sel_stat | sel_clr | sel_en;
  wire wr_ctrl = wr_en & sel_ctrl;
  wire wr_clr = wr_en & sel_clr;
  wire wr_irq_en = wr_en & sel_en;

  // Fault state and stored code
  logic fault;
  logic servo_req;
  logic [3:0] code_tens, code_ones;
  logic [fault_pkg::NUM_IRQ-1:0] irq_stat, irq_en;

  // A reset is refused while any condition is still present, so the
  // fault cannot flicker off for one cycle and re-latch a stale code
  wire reset_ok = fault & wr_ctrl & pwdata[fault_pkg::CTRL_ALARM_RESET] & ~any_alarm;
  wire fault_set = ~fault & any_alarm;
  wire next_fault = fault_set | (fault & ~reset_ok);

  // Simultaneous detections report the most severe: overcurrent first
  wire [3:0] det_tens = alarm_now.overcurrent ? fault_pkg::OC_TENS :
                        alarm_now.overload ? fault_pkg::OL_TENS :
                        fault_pkg::OS_TENS;
  wire [3:0] next_tens = fault_set ? det_tens : (reset_ok ? 4'h0 : code_tens);
  wire [3:0] next_ones = fault_set ? fault_pkg::ALL_ONES :
                         (reset_ok ? 4'h0 : code_ones);

  // Servo request is dropped on fault so motion does not resume by itself
  wire next_servo_req = next_fault ? 1'b0 :
                        (wr_ctrl ? pwdata[fault_pkg::CTRL_SERVO_REQ] : servo_req);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fault <= 1'b0;
      fault_output_pin <= 1'b0;
    end else begin
      fault <= next_fault;
      fault_output_pin <= next_fault;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      servo_req <= 1'b0;
      servo_out_en <= 1'b0;
    end else begin
      servo_req <= next_servo_req;
      servo_out_en <= next_servo_req & ~next_fault;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      code_tens <= 4'h0;
      code_ones <= 4'h0;
    end else begin
      code_tens <= next_tens;
      code_ones <= next_ones;
    end
  end

  // Decimal value of the latched code
  wire [7:0] code_val = 8'({4'h0, code_tens} * fault_pkg::CODE_TEN) + {4'h0, code_ones};

  a_servo_needs_write: assert property (@(posedge clk) disable iff (!nrst)
    (!servo_out_en && !wr_ctrl)
      |=> !servo_out_en)
    else $error("servo output turned on without a request");

  a_req_dropped: assert property (@(posedge clk) disable iff (!nrst)
    fault
      |-> !servo_req)
    else $error("servo request kept during fault");

  a_no_spurious: assert property (@(posedge clk) disable iff (!nrst)
    (!fault && !any_alarm)
      |=> !fault)
    else $error("fault entered without an alarm");

  a_pin_on_alarm: assert property (@(posedge clk) disable iff (!nrst)
    any_alarm
      |=> fault_output_pin)
    else $error("alarm pin low after an alarm");

  a_code_idle: assert property (@(posedge clk) disable iff (!nrst)
    !fault
      |-> (code_val == 8'h00))
    else $error("code held outside the fault state");

  a_code_ones: assert property (@(posedge clk) disable iff (!nrst)
    fault
      |-> (code_ones == fault_pkg::ALL_ONES))
    else $error("latched code has a wrong ones digit");

  a_code_tens: assert property (@(posedge clk) disable iff (!nrst)
    fault
      |-> (code_tens >= fault_pkg::OC_TENS && code_tens <= fault_pkg::OS_TENS))
    else $error("latched code has a wrong tens digit");

  // Interrupts: events set, software clears, set wins over clear
  wire [fault_pkg::NUM_IRQ-1:0] irq_ev;
  assign irq_ev[fault_pkg::IRQ_FAULT] = fault_set;
  assign irq_ev[fault_pkg::IRQ_CLEARED] = reset_ok;
  wire [fault_pkg::NUM_IRQ-1:0] clr_mask = wr_clr ? pwdata[fault_pkg::NUM_IRQ-1:0] : '0;
  wire [fault_pkg::NUM_IRQ-1:0] next_irq_stat = (irq_stat & ~clr_mask) | irq_ev;
  wire [fault_pkg::NUM_IRQ-1:0] next_irq_en =
    wr_irq_en ? pwdata[fault_pkg::NUM_IRQ-1:0] : irq_en;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat <= '0;
      irq_en <= '0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_en <= next_irq_en;
    end
  end

  // Computed from next values so the line rises with its status bit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irq_stat & next_irq_en);
    end
  end

  a_irq_level: assert property (@(posedge clk) disable iff (!nrst)
    irq == |(irq_stat & irq_en))
    else $error("interrupt line differs from enabled status");

  a_irq_set: assert property (@(posedge clk) disable iff (!nrst)
    fault_set
      |=> irq_stat[fault_pkg::IRQ_FAULT])
    else $error("fault entry did not set its status bit");

  a_irq_sticky: assert property (@(posedge clk) disable iff (!nrst)
    (irq_stat[fault_pkg::IRQ_FAULT] && !wr_clr)
      |=> irq_stat[fault_pkg::IRQ_FAULT])
    else $error("fault status bit dropped without a clear");

  a_irq_clear: assert property (@(posedge clk) disable iff (!nrst)
    (wr_clr && pwdata[fault_pkg::IRQ_FAULT] && !fault_set)
      |=> !irq_stat[fault_pkg::IRQ_FAULT])
    else $error("fault status bit not cleared by a clear write");

  a_reset_event: assert property (@(posedge clk) disable iff (!nrst)
    reset_ok
      |=> irq_stat[fault_pkg::IRQ_CLEARED])
    else $error("accepted alarm reset did not set its status bit");

  // Read mux
  wire [31:0] flags_word = {28'h0, fault, 2'h0, servo_out_en};
  wire [31:0] code_word = {24'h0, code_val};
  wire [31:0] ctrl_word = {31'h0, servo_req};
  wire [31:0] stat_word = {30'h0, irq_stat};
  wire [31:0] en_word = {30'h0, irq_en};
  wire [31:0] rd_mux = sel_flags ? flags_word :
                       sel_code ? code_word :
                       sel_ctrl ? ctrl_word :
                       sel_stat ? stat_word :
                       sel_en ? en_word : 32'h0;

  // One wait state: data and response are registered ahead of completion
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= next_pready;
      pslverr <= next_pready & ~mapped;
      prdata <= (next_pready & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  a_ready_wait: assert property (@(posedge clk) disable iff (!nrst)
    (psel && penable && !pready)
      |=> pready)
    else $error("access phase not answered after one wait state");

  a_ready_pulse: assert property (@(posedge clk) disable iff (!nrst)
    pready
      |=> !pready)
    else $error("ready held for more than one cycle");

  a_err_with_ready: assert property (@(posedge clk) disable iff (!nrst)
    pslverr
      |-> pready)
    else $error("error response outside a completion cycle");

  a_unmapped_err: assert property (@(posedge clk) disable iff (!nrst)
    (apb_done && !mapped)
      |-> pslverr)
    else $error("unmapped access completed without error");

  a_mapped_ok: assert property (@(posedge clk) disable iff (!nrst)
    (apb_done && mapped)
      |-> !pslverr)
    else $error("mapped access completed with error");

  a_rdata_idle: assert property (@(posedge clk) disable iff (!nrst)
    !pready
      |-> (prdata == 32'h0))
    else $error("read data driven outside a completion cycle");

  a_wdata_zero: assert property (@(posedge clk) disable iff (!nrst)
    (apb_done && pwrite)
      |-> (prdata == 32'h0))
    else $error("write completion returned read data");

  led_flasher #(
    .ON_CYC(ON_CYC),
    .OFF_CYC(OFF_CYC),
    .GAP_CYC(GAP_CYC),
    .PAUSE_CYC(PAUSE_CYC)
  ) u_flasher (
    .clk(clk),
    .nrst(nrst),
    .run(fault),
    .tens(code_tens),
    .ones(code_ones),
    .led(led)
  );

  a_first_red: assert property (@(posedge clk) disable iff (!nrst)
    $rose(fault)
      |=> led.red)
    else $error("pattern did not open with a red flash");

  a_red_tens: assert property (@(posedge clk) disable iff (!nrst)
    (led.red && fault)
      |-> (code_tens != 4'h0))
    else $error("red flash without a tens digit");

  a_fault_entry: assert property (@(posedge clk) disable iff (!nrst)
    (any_alarm && !fault) |=> (fault && !servo_out_en))
    else $error("alarm did not enter fault with servo off");

  a_servo_off: assert property (@(posedge clk) disable iff (!nrst)
    fault |-> !servo_out_en)
    else $error("servo output on during fault");

  a_status_bit: assert property (@(posedge clk) disable iff (!nrst)
    (apb_done && !pwrite && sel_flags) |-> (prdata[3] == $past(fault)))
    else $error("status bit 3 differs from fault state");

  a_pin_tracks: assert property (@(posedge clk) disable iff (!nrst)
    fault_output_pin == fault)
    else $error("alarm pin differs from fault state");

  a_code_read: assert property (@(posedge clk) disable iff (!nrst)
    (apb_done && !pwrite && sel_code) |-> (prdata == {24'h0, $past(code_val)}))
    else $error("code readback differs from latched code");

  a_code_value: assert property (@(posedge clk) disable iff (!nrst)
    $rose(fault) |-> (code_val == 8'h0b || code_val == 8'h15 || code_val == 8'h1f))
    else $error("fault latched an undefined code");

  a_oc_priority: assert property (@(posedge clk) disable iff (!nrst)
    (!fault && alarm_now.overcurrent) |=> (code_val == 8'h0b))
    else $error("overcurrent not reported as 11");

  a_led_quiet: assert property (@(posedge clk) disable iff (!nrst)
    (!fault)[*2] |-> (!led.red && !led.green))
    else $error("LED lit without fault");

  a_led_starts: assert property (@(posedge clk) disable iff (!nrst)
    $rose(fault) |-> ##[1:2] (led.red || led.green))
    else $error("LED pattern did not start on fault");

  a_one_colour: assert property (@(posedge clk) disable iff (!nrst)
    !(led.red && led.green))
    else $error("red and green lit together");

  a_latch_hold: assert property (@(posedge clk) disable iff (!nrst)
    (fault && !reset_ok) |=> (fault && fault_output_pin && $stable(code_val)))
    else $error("fault indication changed without reset");

  a_clear_all: assert property (@(posedge clk) disable iff (!nrst)
    reset_ok |=> (!fault && !fault_output_pin && code_val == 8'h00))
    else $error("alarm reset did not clear all indications");

  a_reset_refused: assert property (@(posedge clk) disable iff (!nrst)
    (fault && any_alarm) |=> fault)
    else $error("fault left while condition still present");

endmodule : servo_alarm_fault_reporter

// File: dv/apb_host_model.sv
// Host controller model: APB requester that reads alarm state and issues alarm resets
`timescale 1ns/1ps
module apb_host_model (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end

  // Request held until pready is sampled high; no cycle count is assumed
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // Code is read before the reset; the caller has already removed the cause
  task clear_alarm(output logic [31:0] code);
    logic e;
    logic [31:0] wr_rd;
    xfer(1'b0, fault_pkg::ADDR_CODE, 32'h00000000, code, e);
    xfer(1'b1, fault_pkg::ADDR_CTRL, 32'h00000002, wr_rd, e);
  endtask : clear_alarm
endmodule : apb_host_model

// File: dv/servo_alarm_fault_reporter_tb_top.sv
// Self-checking bench of the servo alarm and fault reporter
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  $display("MISMATCH %s expected %h seen %h", n, e, g); errors++; end end
module servo_alarm_fault_reporter_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, servo_out_en, fault_output_pin, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  fault_pkg::alarm_in_t alarm_in = '0;
  fault_pkg::led_t led;
  int errors = 0;
  int total_checks = 0;

  always #5 clk = ~clk;

  apb_host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  servo_alarm_fault_reporter #(.ON_CYC(4), .OFF_CYC(4), .GAP_CYC(8), .PAUSE_CYC(12)) uut (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alarm_in(alarm_in), .servo_out_en(servo_out_en), .fault_output_pin(fault_output_pin),
    .led(led), .irq(irq));

  task rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h00000000, rd, err);
    `CHK(n, e, rd)
  endtask : rd_chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd, err);
  endtask : wr

  task t_reset;
    rd_chk("flags", fault_pkg::ADDR_FLAGS, 32'h00000000);
    rd_chk("code", fault_pkg::ADDR_CODE, 32'h00000000);
    wr(fault_pkg::ADDR_FLAGS, 32'h0000ffff);
    rd_chk("flags ro", fault_pkg::ADDR_FLAGS, 32'h00000000);
    host.xfer(1'b0, 8'h3c, 32'h00000000, rd, err);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h00000000, rd)
    `CHK("led dark", 2'b00, led)
  endtask : t_reset

  // One full pattern, counted from the first red rise
  task count_flash(input int tens, input int ones);
    int r, g, n, p, both;
    logic pr, pg;
    p = tens * 8 + 8 + ones * 8 + 12;
    n = 0;
    while (led.red !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    r = 1;
    g = 0;
    both = 0;
    pr = 1'b1;
    pg = 1'b0;
    for (n = 1; n < p; n++) begin
      @(posedge clk);
      #1;
      if (led.red === 1'b1 && pr !== 1'b1) r++;
      if (led.green === 1'b1 && pg !== 1'b1) g++;
      if (led.red === 1'b1 && led.green === 1'b1) both++;
      if (led.green === 1'b1 && r < tens) both++;
      pr = led.red;
      pg = led.green;
    end
    `CHK("red flashes", tens, r)
    `CHK("green flashes", ones, g)
    `CHK("colour order", 0, both)
  endtask : count_flash

  task t_alarm(input int idx);
    logic [31:0] code;
    logic en;
    code = 32'(10 * (idx + 1) + 1);
    en = (idx != 2);
    wr(fault_pkg::ADDR_IRQ_CLR, 32'h00000003);
    wr(fault_pkg::ADDR_IRQ_EN, {31'h0, en});
    rd_chk("irq en", fault_pkg::ADDR_IRQ_EN, {31'h0, en});
    wr(fault_pkg::ADDR_CTRL, 32'h00000001);
    #1;
    `CHK("servo on", 1'b1, servo_out_en)
    rd_chk("servo req", fault_pkg::ADDR_CTRL, 32'h00000001);
    rd_chk("flags servo", fault_pkg::ADDR_FLAGS, 32'h00000001);
    @(posedge clk);
    alarm_in <= fault_pkg::alarm_in_t'(3'b001 << idx);
    repeat (3) @(posedge clk);
    #1;
    `CHK("servo off", 1'b0, servo_out_en)
    `CHK("alarm pin", 1'b1, fault_output_pin)
    count_flash(idx + 1, 1);
    rd_chk("flags fault", fault_pkg::ADDR_FLAGS, 32'h00000008);
    rd_chk("code", fault_pkg::ADDR_CODE, code);
    #1;
    `CHK("irq level", en, irq)
    wr(fault_pkg::ADDR_CTRL, 32'h00000002);
    rd_chk("held by cause", fault_pkg::ADDR_FLAGS, 32'h00000008);
    @(posedge clk);
    alarm_in <= '0;
    repeat (3) @(posedge clk);
    host.clear_alarm(rd);
    #1;
    `CHK("pin cleared", 1'b0, fault_output_pin)
    rd_chk("code cleared", fault_pkg::ADDR_CODE, 32'h00000000);
    rd_chk("flags cleared", fault_pkg::ADDR_FLAGS, 32'h00000000);
    rd_chk("irq stat", fault_pkg::ADDR_IRQ_STAT, 32'h00000003);
    wr(fault_pkg::ADDR_IRQ_CLR, 32'h00000001);
    #1;
    `CHK("irq cleared", 1'b0, irq)
    `CHK("led off", 2'b00, led)
  endtask : t_alarm

  // Two alarms at once, then a third one while already in fault
  task t_priority;
    @(posedge clk);
    alarm_in <= fault_pkg::alarm_in_t'(3'b110);
    repeat (4) @(posedge clk);
    alarm_in <= fault_pkg::alarm_in_t'(3'b111);
    repeat (4) @(posedge clk);
    rd_chk("priority code", fault_pkg::ADDR_CODE, 32'h00000015);
    @(posedge clk);
    alarm_in <= '0;
    repeat (3) @(posedge clk);
    host.clear_alarm(rd);
    `CHK("code read first", 32'h00000015, rd)
    rd_chk("cleared", fault_pkg::ADDR_FLAGS, 32'h00000000);
  endtask : t_priority

  task print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    for (int i = 0; i < 3; i++) t_alarm(i);
    t_priority();
    print_verdict();
  end

  // Whole run is well under 2000 cycles
  initial begin
    #200000;
    errors++;
    print_verdict();
  end
endmodule : servo_alarm_fault_reporter_tb_top
